// ===== hdl/ports_eh_pkg.sv
/*
 * shared constants and carriers of the parallel ports block:
 * register offsets, field positions, reset values and bus records.
 * assumes an 8-bit register address and 8-bit data.
 */
package ports_eh_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] LOW_ADDR_PORT_DIRECTION   = 8'h03;
  localparam logic [7:0] LOW_ADDR_PORT_DATA        = 8'h05;
  localparam logic [7:0] ANALOG_INPUT_PORT_DATA    = 8'h0A;
  localparam logic [7:0] PULLUP_ASSIGNMENT         = 8'h2C;
  localparam logic [7:0] PWM_SERIAL_PORT_DATA      = 8'h7C;
  localparam logic [7:0] PWM_SERIAL_PORT_DIRECTION = 8'h7D;
  localparam logic [7:0] BUS_CTRL_PORT_DATA        = 8'h7E;
  localparam logic [7:0] BUS_CTRL_PORT_DIRECTION   = 8'h7F;

  // ==========================================================
  // pull-up assignment fields and reset values
  localparam int unsigned HIGH_ADDR_PULL_BIT  = 0;
  localparam int unsigned LOW_ADDR_PULL_BIT   = 1;
  localparam int unsigned BUS_CTRL_PULL_BIT   = 2;
  localparam int unsigned PWM_SERIAL_PULL_BIT = 3;
  localparam int unsigned RW_STROBE_BIT       = 7;
  localparam logic [3:0] PULLUP_RESET        = 4'hF;
  localparam logic [7:0] DIRECTION_RESET     = 8'h00;
  localparam logic [7:0] READ_IDLE           = 8'h00;
  localparam logic [7:0] ALL_OUT             = 8'hFF;
  localparam logic [7:0] BUS_CTRL_PULL_MASK  = 8'h7F;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_type;

  typedef struct packed {
    logic       high_addr;
    logic       low_addr;
    logic [7:0] bus_ctrl;
    logic       pwm_serial;
  } pull_type;

endpackage

// ===== hdl/parallel_ports_e_to_h.sv
/*
 * parallel ports block: analog-shared input port, low-address
 * port, bus-control port and pwm/serial port, plus the pull-up
 * assignment register and the pad pull controls.
 * assumes synchronous pin inputs, a plain register port with read
 * data one cycle after the read strobe, and external pads that
 * resolve out/oe and apply the pull enables.
 */
// Notes on behaviour
// - analog port: read-only data, never reset
// - analog pins are converter inputs, start high-z
// - direction bit one means output; reset zero
// - expanded mode: low-address pins drive address, low-address registers unmapped
// - single-chip: low-address pins inputs with pull-ups
// - low-address, bus-control data kept across reset
// - bus-control bit seven is read/write strobe in expanded mode, a plain port pin in single-chip
// - bus-control bits six-zero reset to pulled inputs
// - pwm/serial pins double as pwm and serial
// - alternate function pins ignore data writes
// - pwm/serial inputs: upper pulled up, lower down
// - pull-up assignment: four enables, reset 0F
// - enable bit gates all pull-ups together
// - enable low turns every pull off
// - pwm/serial enable switches all eight resistors
// - address-port pull enables void in expanded
`timescale 1ns/100ps

module parallel_ports_e_to_h (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire ports_eh_pkg::reg_req_type   req,
  output logic [7:0]                       rd_data,
  input  wire logic                        expanded_mode,
  input  wire logic                        assignment_reg_enable,
  input  wire logic [7:0]                  analog_pins_in,
  input  wire logic [7:0]                  low_addr_pins_in,
  input  wire logic [7:0]                  address_low,
  output ports_eh_pkg::pin_drive_type      low_addr_pins,
  input  wire logic [7:0]                  bus_ctrl_pins_in,
  input  wire logic                        rw_strobe,
  output ports_eh_pkg::pin_drive_type      bus_ctrl_pins,
  input  wire logic [7:0]                  pwm_serial_pins_in,
  input  wire logic [7:0]                  pwm_serial_alt_en,
  input  wire logic [7:0]                  pwm_serial_alt_out,
  input  wire logic [7:0]                  pwm_serial_alt_oe,
  output ports_eh_pkg::pin_drive_type      pwm_serial_pins,
  output ports_eh_pkg::pull_type           pulls
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [7:0]                  low_dir;
    logic [7:0]                  low_data;
    logic [7:0]                  ctrl_dir;
    logic [7:0]                  ctrl_data;
    logic [7:0]                  pwm_dir;
    logic [7:0]                  pwm_data;
    logic [3:0]                  pull_assign;
    logic [7:0]                  rdata;
    ports_eh_pkg::pin_drive_type low_pins;
    ports_eh_pkg::pin_drive_type ctrl_pins;
    ports_eh_pkg::pin_drive_type pwm_pins;
    ports_eh_pkg::pull_type      pull;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ==========================================================
  // helpers
  // inputs show the pad, outputs the latch
  function automatic logic [7:0] read_view(
    input logic [7:0] dir,
    input logic [7:0] latch,
    input logic [7:0] pins
  );
    read_view = (dir & latch) | (~dir & pins);
  endfunction

  // latch value only reaches pads that are outputs
  function automatic ports_eh_pkg::pin_drive_type gp_drive(
    input logic [7:0] dir,
    input logic [7:0] latch
  );
    ports_eh_pkg::pin_drive_type d;
    d.oe  = dir;
    d.out = dir & latch;
    gp_drive = d;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic       low_mapped;
    logic       pulls_on;
    state_type  n;
    n = state_reg;
    low_mapped = ~expanded_mode;
    pulls_on = assignment_reg_enable;
    n.rdata = ports_eh_pkg::READ_IDLE;

    // register writes
    if (req.wr) begin
      case (req.addr)
        ports_eh_pkg::LOW_ADDR_PORT_DIRECTION: begin
          if (low_mapped) begin
            n.low_dir = req.wdata;
          end
        end
        ports_eh_pkg::LOW_ADDR_PORT_DATA: begin
          if (low_mapped) begin
            n.low_data = req.wdata;
          end
        end
        ports_eh_pkg::PULLUP_ASSIGNMENT: begin
          n.pull_assign = req.wdata[3:0];
        end
        ports_eh_pkg::PWM_SERIAL_PORT_DATA: begin
          n.pwm_data = req.wdata;
        end
        ports_eh_pkg::PWM_SERIAL_PORT_DIRECTION: begin
          n.pwm_dir = req.wdata;
        end
        ports_eh_pkg::BUS_CTRL_PORT_DATA: begin
          n.ctrl_data = req.wdata;
        end
        ports_eh_pkg::BUS_CTRL_PORT_DIRECTION: begin
          n.ctrl_dir = req.wdata;
        end
        default: begin
        end
      endcase
    end

    // register reads; unmapped offsets answer zero
    if (req.rd) begin
      case (req.addr)
        ports_eh_pkg::LOW_ADDR_PORT_DIRECTION: begin
          n.rdata = low_mapped ? state_reg.low_dir
                               : ports_eh_pkg::READ_IDLE;
        end
        ports_eh_pkg::LOW_ADDR_PORT_DATA: begin
          n.rdata = low_mapped
            ? read_view(state_reg.low_dir, state_reg.low_data,
                        low_addr_pins_in)
            : ports_eh_pkg::READ_IDLE;
        end
        ports_eh_pkg::ANALOG_INPUT_PORT_DATA: begin
          n.rdata = analog_pins_in;
        end
        ports_eh_pkg::PULLUP_ASSIGNMENT: begin
          n.rdata = {4'h0, state_reg.pull_assign};
        end
        ports_eh_pkg::PWM_SERIAL_PORT_DATA: begin
          n.rdata = read_view(state_reg.pwm_dir, state_reg.pwm_data,
                              pwm_serial_pins_in);
        end
        ports_eh_pkg::PWM_SERIAL_PORT_DIRECTION: begin
          n.rdata = state_reg.pwm_dir;
        end
        ports_eh_pkg::BUS_CTRL_PORT_DATA: begin
          n.rdata = read_view(state_reg.ctrl_dir, state_reg.ctrl_data,
                              bus_ctrl_pins_in);
        end
        ports_eh_pkg::BUS_CTRL_PORT_DIRECTION: begin
          n.rdata = state_reg.ctrl_dir;
        end
        default: begin
          n.rdata = ports_eh_pkg::READ_IDLE;
        end
      endcase
    end

    // reset: control state only, data latches keep their value
    if (rst) begin
      n.low_dir     = ports_eh_pkg::DIRECTION_RESET;
      n.ctrl_dir    = ports_eh_pkg::DIRECTION_RESET;
      n.pwm_dir     = ports_eh_pkg::DIRECTION_RESET;
      n.pull_assign = ports_eh_pkg::PULLUP_RESET;
      n.rdata       = ports_eh_pkg::READ_IDLE;
    end

    // low-address pads
    if (expanded_mode) begin
      n.low_pins.out = address_low;
      n.low_pins.oe  = ports_eh_pkg::ALL_OUT;
    end else begin
      n.low_pins = gp_drive(n.low_dir, n.low_data);
    end

    // bus-control pads; bit seven is the strobe when expanded
    n.ctrl_pins = gp_drive(n.ctrl_dir, n.ctrl_data);
    if (expanded_mode) begin
      n.ctrl_pins.out[ports_eh_pkg::RW_STROBE_BIT] = rw_strobe;
      n.ctrl_pins.oe[ports_eh_pkg::RW_STROBE_BIT]  = 1'b1;
    end

    // pwm/serial pads; alternate functions own their pads
    n.pwm_pins = gp_drive(n.pwm_dir, n.pwm_data);
    for (int i = 0; i < 8; i++) begin
      if (pwm_serial_alt_en[i]) begin
        n.pwm_pins.out[i] = pwm_serial_alt_out[i];
        n.pwm_pins.oe[i]  = pwm_serial_alt_oe[i];
      end
    end

    // pulls: the pad decides pull-up or pull-down per pin
    n.pull.high_addr = pulls_on & ~expanded_mode
      & n.pull_assign[ports_eh_pkg::HIGH_ADDR_PULL_BIT];
    n.pull.low_addr = pulls_on & ~expanded_mode
      & n.pull_assign[ports_eh_pkg::LOW_ADDR_PULL_BIT];
    n.pull.bus_ctrl = (pulls_on
      & n.pull_assign[ports_eh_pkg::BUS_CTRL_PULL_BIT])
      ? ports_eh_pkg::BUS_CTRL_PULL_MASK
      : ports_eh_pkg::READ_IDLE;
    n.pull.pwm_serial = pulls_on
      & n.pull_assign[ports_eh_pkg::PWM_SERIAL_PULL_BIT];

    state_next = n;
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // ==========================================================
  // outputs
  assign rd_data         = state_reg.rdata;
  assign low_addr_pins   = state_reg.low_pins;
  assign bus_ctrl_pins   = state_reg.ctrl_pins;
  assign pwm_serial_pins = state_reg.pwm_pins;
  assign pulls           = state_reg.pull;

  // ==========================================================
  // elaboration checks
  // pads, latches and read data are eight bits wide throughout
  if ($bits(ports_eh_pkg::pin_drive_type) != 16) begin : g_pad_width
    $error("pad record must carry eight pins");
  end
  if (ports_eh_pkg::RW_STROBE_BIT > 7) begin : g_strobe_bit
    $error("strobe bit lies outside the bus-control port");
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic past_valid_reg;
  always_ff @(posedge sys_clk) begin
    past_valid_reg <= 1'b1;
  end

  // latches start unknown; compare them only once software wrote both
  logic [1:0] written_reg = 2'b00;
  always_ff @(posedge sys_clk) begin
    if (req.wr && req.addr == ports_eh_pkg::BUS_CTRL_PORT_DATA) begin
      written_reg[0] <= 1'b1;
    end
    if (req.wr && req.addr == ports_eh_pkg::PWM_SERIAL_PORT_DATA) begin
      written_reg[1] <= 1'b1;
    end
  end

  chk_dir_reset: assert property (
    past_valid_reg && $past(rst) |->
      state_reg.low_dir == 8'h00 && state_reg.ctrl_dir == 8'h00
      && state_reg.pwm_dir == 8'h00 && pwm_serial_pins.oe
         == $past(pwm_serial_alt_en & pwm_serial_alt_oe))
    else $error("direction not cleared by reset");

  chk_pull_reset: assert property (
    past_valid_reg && $past(rst) |-> state_reg.pull_assign == 4'hF)
    else $error("pull-up assignment reset value wrong");

  chk_data_kept: assert property (
    past_valid_reg && &written_reg && $past(rst) && !$past(req.wr) |->
      state_reg.ctrl_data == $past(state_reg.ctrl_data)
      && state_reg.pwm_data == $past(state_reg.pwm_data))
    else $error("reset altered a data latch");

  chk_low_addr_drive: assert property (
    expanded_mode ##1 expanded_mode |->
      low_addr_pins.oe == 8'hFF
      && low_addr_pins.out == $past(address_low))
    else $error("address not driven in expanded mode");

  chk_low_unmapped: assert property (
    expanded_mode && req.rd && req.addr == 8'h05 |=>
      rd_data == 8'h00)
    else $error("low-address data visible in expanded mode");

  chk_rw_strobe: assert property (
    expanded_mode |=> bus_ctrl_pins.oe[7]
      && bus_ctrl_pins.out[7] == $past(rw_strobe))
    else $error("strobe not on bus-control bit seven");

  chk_pull_gate: assert property (
    !assignment_reg_enable |=> pulls == '0)
    else $error("pull active while assignments disabled");

  chk_alt_owns: assert property (
    pwm_serial_alt_en[0] && req.wr && req.addr == 8'h7C |=>
      pwm_serial_pins.out[0] == $past(pwm_serial_alt_out[0]))
    else $error("data write reached an alternate pin");

  chk_read_mix: assert property (
    req.rd && req.addr == 8'h7E |=> rd_data ==
      (($past(state_reg.ctrl_dir) & $past(state_reg.ctrl_data))
      | (~$past(state_reg.ctrl_dir) & $past(bus_ctrl_pins_in))))
    else $error("bus-control read mixes pins wrongly");

  chk_analog_read: assert property (
    req.rd && req.addr == 8'h0A |=>
      rd_data == $past(analog_pins_in))
    else $error("analog port read wrong");

  chk_addr_pulls_off: assert property (
    expanded_mode |=> !pulls.low_addr && !pulls.high_addr)
    else $error("address-port pull active in expanded mode");

  chk_low_pull_sel: assert property (
    assignment_reg_enable && !expanded_mode |=> pulls.low_addr
      == state_reg.pull_assign[ports_eh_pkg::LOW_ADDR_PULL_BIT])
    else $error("low-address pull does not follow its enable");

  chk_ctrl_pull_sel: assert property (
    assignment_reg_enable |=> pulls.bus_ctrl
      == (state_reg.pull_assign[ports_eh_pkg::BUS_CTRL_PULL_BIT]
          ? ports_eh_pkg::BUS_CTRL_PULL_MASK : 8'h00))
    else $error("bus-control pulls do not follow their enable");

  chk_pwm_pull_sel: assert property (
    assignment_reg_enable |=> pulls.pwm_serial
      == state_reg.pull_assign[ports_eh_pkg::PWM_SERIAL_PULL_BIT])
    else $error("pwm/serial resistors do not follow their enable");

  chk_assign_read: assert property (
    req.rd && req.addr == ports_eh_pkg::PULLUP_ASSIGNMENT |=>
      rd_data == {4'h0, $past(state_reg.pull_assign)})
    else $error("pull-up assignment read wrong");

  chk_dir_write: assert property (
    req.wr && req.addr == ports_eh_pkg::BUS_CTRL_PORT_DIRECTION |=>
      bus_ctrl_pins.oe[6:0] == $past(req.wdata[6:0]))
    else $error("direction write did not reach the pads");

  chk_strobe_pin_gp: assert property (
    !expanded_mode |=>
      bus_ctrl_pins.oe[7] == state_reg.ctrl_dir[7])
    else $error("bit seven not a plain port pin in single-chip mode");

  chk_low_dir_locked: assert property (
    expanded_mode && req.wr
      && req.addr == ports_eh_pkg::LOW_ADDR_PORT_DIRECTION |=>
      state_reg.low_dir == $past(state_reg.low_dir))
    else $error("low-address direction written in expanded mode");

  chk_alt_drive: assert property (
    pwm_serial_alt_en != 8'h00 |=>
      (pwm_serial_pins.oe & $past(pwm_serial_alt_en))
      == ($past(pwm_serial_alt_oe) & $past(pwm_serial_alt_en)))
    else $error("alternate function lost its pad");

  chk_pwm_gp_drive: assert property (
    pwm_serial_alt_en != 8'hFF |=>
      (pwm_serial_pins.oe & ~$past(pwm_serial_alt_en))
      == (state_reg.pwm_dir & ~$past(pwm_serial_alt_en)))
    else $error("pwm/serial direction not on its pads");

  cov_analog_read: cover property (req.rd && req.addr == 8'h0A);
  cov_expanded_write: cover property (
    expanded_mode && req.wr && req.addr == 8'h05);
  cov_alt_write: cover property (
    pwm_serial_alt_en != 8'h00 && req.wr && req.addr == 8'h7C);
  cov_back_to_back: cover property (req.wr ##1 req.rd);
  cov_expanded_strobe: cover property (expanded_mode && rw_strobe);

endmodule

// ===== verification/tb_top.sv
/*
 * self-checking bench of the parallel ports block: random pads,
 * modes and register traffic with shadow expectations.
 * assumes the package and the block compiled from hdl/.
 */
`timescale 1ns/100ps
module tb_top;
  // ========================================================
  // stimulus and observation
  logic                        sys_clk = 1'b0;
  logic                        rst     = 1'b1;
  ports_eh_pkg::reg_req_type   req     = '0;
  logic [7:0]                  rd_data;
  logic                        xm      = 1'b0;
  logic                        pen     = 1'b1;
  logic                        rws     = 1'b0;
  logic [7:0]                  an      = '0;
  logic [7:0]                  pin [3] = '{default: '0};
  logic [7:0]                  al      = '0;
  logic [7:0]                  aen     = '0;
  logic [7:0]                  aout    = '0;
  logic [7:0]                  aoe     = '0;
  ports_eh_pkg::pin_drive_type pad [3];
  ports_eh_pkg::pull_type      pulls;
  logic [7:0]                  dir [3];
  logic [7:0]                  lat [3];
  logic [3:0]                  pullup_assignment;
  int                          mismatches = 0;
  int                          compares   = 0;
  localparam logic [7:0] DAT [3] = '{ports_eh_pkg::LOW_ADDR_PORT_DATA,
    ports_eh_pkg::BUS_CTRL_PORT_DATA, ports_eh_pkg::PWM_SERIAL_PORT_DATA};
  localparam logic [7:0] DRR [3] = '{ports_eh_pkg::LOW_ADDR_PORT_DIRECTION,
    ports_eh_pkg::BUS_CTRL_PORT_DIRECTION,
    ports_eh_pkg::PWM_SERIAL_PORT_DIRECTION};
  localparam logic [7:0] ADR [9] = '{DAT[0], DAT[1], DAT[2], DRR[0],
    DRR[1], DRR[2], ports_eh_pkg::ANALOG_INPUT_PORT_DATA,
    ports_eh_pkg::PULLUP_ASSIGNMENT, 8'h01};

  always #4 sys_clk = ~sys_clk;

  parallel_ports_e_to_h i_dut (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .req                   (req),
    .rd_data               (rd_data),
    .expanded_mode         (xm),
    .assignment_reg_enable (pen),
    .analog_pins_in        (an),
    .low_addr_pins_in      (pin[0]),
    .address_low           (al),
    .low_addr_pins         (pad[0]),
    .bus_ctrl_pins_in      (pin[1]),
    .rw_strobe             (rws),
    .bus_ctrl_pins         (pad[1]),
    .pwm_serial_pins_in    (pin[2]),
    .pwm_serial_alt_en     (aen),
    .pwm_serial_alt_out    (aout),
    .pwm_serial_alt_oe     (aoe),
    .pwm_serial_pins       (pad[2]),
    .pulls                 (pulls)
  );

  // ========================================================
  // expectations
  function automatic logic [7:0] rd_exp(logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == ports_eh_pkg::ANALOG_INPUT_PORT_DATA) r = an;
    if (a == ports_eh_pkg::PULLUP_ASSIGNMENT) r = {4'h0, pullup_assignment};
    for (int i = 0; i < 3; i++) begin
      if (i > 0 || !xm) begin
        if (a == DAT[i]) r = (dir[i] & lat[i]) | (~dir[i] & pin[i]);
        if (a == DRR[i]) r = dir[i];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] pad_exp(int i);
    logic [7:0] o;
    logic [7:0] e;
    o = dir[i] & lat[i];
    e = dir[i];
    if (i == 0 && xm) begin
      o = al;
      e = 8'hFF;
    end
    if (i == 1 && xm) begin
      o[7] = rws;
      e[7] = 1'b1;
    end
    // alternate owner masks both latch and direction
    if (i == 2) begin
      o = (o & ~aen) | (aout & aen);
      e = (e & ~aen) | (aoe & aen);
    end
    return {o, e};
  endfunction

  function automatic logic [15:0] pull_exp();
    return {5'h00, pen & pullup_assignment[0] & ~xm, pen & pullup_assignment[1] & ~xm, 1'b0,
            {7{pen & pullup_assignment[2]}}, pen & pullup_assignment[3]};
  endfunction

  // ========================================================
  // bus and comparison tasks
  task automatic check(string nm, logic [15:0] seen, logic [15:0] ex);
    compares++;
    if (seen !== ex) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (i > 0 || !xm) begin
        if (a == DAT[i]) lat[i] = d;
        if (a == DRR[i]) dir[i] = d;
      end
    end
    if (a == ports_eh_pkg::PULLUP_ASSIGNMENT) pullup_assignment = d[3:0];
  endtask

  task automatic rd(logic [7:0] a);
    logic [7:0] ex;
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    ex = rd_exp(a);
    @(negedge sys_clk);
    check("rd_data", 16'(rd_data), 16'(ex));
    @(negedge sys_clk);
    check("rd_idle", 16'(rd_data), 16'h0000);
  endtask

  task automatic check_all();
    @(posedge sys_clk);
    @(negedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      check($sformatf("pad%0d", i), pad[i], pad_exp(i));
    end
    check("pulls", 16'(pulls), pull_exp());
  endtask

  task automatic stim(bit mode);
    @(posedge sys_clk);
    xm   <= mode & ($urandom_range(3) == 0);
    pen  <= ($urandom_range(3) != 0);
    rws  <= 1'($urandom);
    an   <= 8'($urandom);
    al   <= 8'($urandom);
    aen  <= 8'($urandom);
    aout <= 8'($urandom);
    aoe  <= 8'($urandom);
    for (int i = 0; i < 3; i++) begin
      pin[i] <= 8'($urandom);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ========================================================
  // main sequence
  initial begin
    void'($urandom(32'h7D193746));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    dir = '{default: ports_eh_pkg::DIRECTION_RESET};
    pullup_assignment = ports_eh_pkg::PULLUP_RESET;
    check_all();
    for (int i = 0; i < 3; i++) begin
      wr(DAT[i], 8'($urandom));
      rd(DRR[i]);
    end
    rd(ports_eh_pkg::PULLUP_ASSIGNMENT);
    wr(ports_eh_pkg::ANALOG_INPUT_PORT_DATA, 8'hA5);
    rd(ports_eh_pkg::ANALOG_INPUT_PORT_DATA);
    rd(8'h01);
    wr(ports_eh_pkg::PULLUP_ASSIGNMENT, 8'hF0);
    check_all();
    wr(ports_eh_pkg::PULLUP_ASSIGNMENT, 8'hFF);
    rd(ports_eh_pkg::PULLUP_ASSIGNMENT);
    // first third stays single-chip, then modes mix
    for (int n = 0; n < 60; n++) begin
      stim(n >= 20);
      wr(ADR[$urandom_range(8)], 8'($urandom));
      rd(ADR[$urandom_range(8)]);
      check_all();
    end
    // reset in mid-run keeps the data latches
    @(posedge sys_clk);
    xm  <= 1'b0;
    aen <= 8'h00;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    dir = '{default: ports_eh_pkg::DIRECTION_RESET};
    pullup_assignment = ports_eh_pkg::PULLUP_RESET;
    check_all();
    for (int i = 0; i < 3; i++) begin
      wr(DRR[i], ports_eh_pkg::ALL_OUT);
      rd(DAT[i]);
    end
    summarize();
  end

  // about 500 cycles expected; 12500 cycles, some 25 times that, cuts a hang
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
